/* File: src/kwu_params.svh */
`ifndef KWU_PARAMS_SVH
`define KWU_PARAMS_SVH

// register byte addresses (printed offset not a multiple of four: index times four)
`define KWU_IDX_KEY_WAKE_ENABLE   12'hf9a
`define KWU_ADDR_KEY_WAKE_ENABLE  14'h3e68
`define KWU_ADDR_CTRL             14'h3e6c
`define KWU_ADDR_STATUS           14'h3e70

// field positions
`define KWU_EN_LSB                4
`define KWU_EN_MSB                7
`define KWU_CTRL_RELM             0
`define KWU_CTRL_STOP_REQ         1

// reset values
`define KWU_EN_RESET              4'h0
`define KWU_RELM_RESET            1'b0

`endif

/* File: src/kwu_pkg.sv */
package kwu_pkg;

    typedef enum logic [1:0] {
        KWU_RUN    = 2'b00,
        KWU_STOP   = 2'b01,
        KWU_WARMUP = 2'b10
    } kwu_mode_t;

    typedef struct packed {
        logic       stop_pin;
        logic [3:0] key_pins;
    } kwu_pins_t;

    typedef struct packed {
        logic [3:0] en;
        logic       relm;
        kwu_pins_t  s1;
        kwu_pins_t  s2;
        kwu_pins_t  s3;
        kwu_pins_t  stable;
        logic       stop_prev;
        kwu_mode_t  mode;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
        logic       in_stop;
        logic       warmup;
    } kwu_state_t;

endpackage : kwu_pkg

/* File: src/kwu_key_wakeup.sv */
`include "kwu_params.svh"
//
// Contract
// (RQ1) four write-only enables, bit7 input five down
// (RQ2) enables cleared at reset, low nibble undefined
// (RQ3) enabled low key input releases stop
// (RQ4) active release source refuses stop, starts warm-up
// (RQ5) level mode: primary high or key low
// (RQ6) edge mode: primary rising edge only
// (RQ7) software checks key inputs high before stop
// (RQ8) software sets key pins as inputs
// (RQ9) primary release pin always enabled source
// (RQ10) primary pin held low for key release
// (RQ11) enabled key inputs not analog in stop
// (RQ12) all release conditions ORed into one request
//
module kwu_key_wakeup
    import kwu_pkg::*;
(
    input  wire logic        pclk,          // system clock 125 MHz
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [13:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    input  wire logic        stop_pin,      // primary release pin
    input  wire logic        key_wake_input_two,   // key wake input 2
    input  wire logic        key_wake_input_three, // key wake input 3
    input  wire logic        key_wake_input_four,  // key wake input 4
    input  wire logic        key_wake_input_five,  // key wake input 5
    output logic             in_stop,       // device is in stop mode
    output logic             warmup_start   // one-cycle warm-up start pulse
);

    kwu_state_t st_reg;
    kwu_state_t st_next;
    kwu_pins_t  raw;
    logic       key_req;
    logic       prim_level;
    logic       prim_edge;
    logic       release_req;
    logic       access;
    logic       stop_cmd;

    assign raw = '{stop_pin: stop_pin,
                   key_pins: {key_wake_input_five, key_wake_input_four,
                              key_wake_input_three, key_wake_input_two}};

    // ************************************************************
    // release request
    // ************************************************************
    function automatic logic key_low(input logic [3:0] en, input logic [3:0] pins);
        key_low = |(en & ~pins);
    endfunction : key_low

    always_comb begin
        key_req    = key_low(st_reg.en, st_reg.stable.key_pins);              // RQ3
        prim_level = st_reg.stable.stop_pin;                                  // RQ9
        prim_edge  = st_reg.stable.stop_pin & ~st_reg.stop_prev;
        if (st_reg.relm) begin
            release_req = prim_level | key_req;                               // RQ5 RQ12
        end else begin
            release_req = prim_edge;                                          // RQ6
        end
    end

    assign access   = psel & penable;
    assign stop_cmd = access & pwrite & (paddr == `KWU_ADDR_CTRL)
                      & pwdata[`KWU_CTRL_STOP_REQ];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next         = st_reg;
        st_next.s1      = raw;
        st_next.s2      = st_reg.s1;
        st_next.s3      = st_reg.s2;
        st_next.warmup  = 1'b0;
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.prdata  = 32'h0000_0000;
        if (st_reg.s2.stop_pin == st_reg.s3.stop_pin) begin
            st_next.stable.stop_pin = st_reg.s2.stop_pin;
        end
        for (int i = 0; i < 4; i++) begin
            if (st_reg.s2.key_pins[i] == st_reg.s3.key_pins[i]) begin
                st_next.stable.key_pins[i] = st_reg.s2.key_pins[i];
            end
        end
        st_next.stop_prev = st_reg.stable.stop_pin;

        // one wait state: answer on the cycle after the access phase begins
        if (access && !st_reg.pready) begin
            st_next.pready = 1'b1;
            unique case (paddr)
                `KWU_ADDR_KEY_WAKE_ENABLE: begin
                    if (pwrite) begin
                        st_next.en = pwdata[`KWU_EN_MSB:`KWU_EN_LSB];         // RQ1
                    end
                end
                `KWU_ADDR_CTRL: begin
                    if (pwrite) begin
                        st_next.relm = pwdata[`KWU_CTRL_RELM];
                    end else begin
                        st_next.prdata = {31'h0000_0000, st_reg.relm};
                    end
                end
                `KWU_ADDR_STATUS: begin
                    if (!pwrite) begin
                        st_next.prdata = {25'h000_0000, release_req, st_reg.stable.stop_pin,
                                          st_reg.stable.key_pins, st_reg.in_stop};
                    end
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end

        unique case (st_reg.mode)
            KWU_RUN: begin
                if (stop_cmd && !st_reg.pready) begin
                    if ((st_reg.relm & release_req) | prim_level | key_req) begin
                        st_next.mode   = KWU_WARMUP;                          // RQ4
                        st_next.warmup = 1'b1;
                    end else begin
                        st_next.mode = KWU_STOP;
                    end
                end
            end
            KWU_STOP: begin
                if (release_req) begin                                        // RQ12
                    st_next.mode   = KWU_WARMUP;
                    st_next.warmup = 1'b1;
                end
            end
            KWU_WARMUP: st_next.mode = KWU_RUN;
            default:    st_next.mode = KWU_RUN;
        endcase
        st_next.in_stop = (st_next.mode == KWU_STOP);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg        <= '0;
            st_reg.en     <= `KWU_EN_RESET;                                   // RQ2
            st_reg.relm   <= `KWU_RELM_RESET;
            st_reg.s1     <= '{stop_pin: 1'b0, key_pins: 4'hf};
            st_reg.s2     <= '{stop_pin: 1'b0, key_pins: 4'hf};
            st_reg.s3     <= '{stop_pin: 1'b0, key_pins: 4'hf};
            st_reg.stable <= '{stop_pin: 1'b0, key_pins: 4'hf};
            st_reg.mode   <= KWU_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata       = st_reg.prdata;
    assign pready       = st_reg.pready;
    assign pslverr      = st_reg.pslverr;
    assign in_stop      = st_reg.in_stop;
    assign warmup_start = st_reg.warmup;

    // ************************************************************
    // assertions
    // ************************************************************
    enable_reset_a: assert property (@(posedge pclk)                          // RQ2
        $rose(presetn) |-> st_reg.en == 4'h0)
        else $error("enables not cleared at reset");

    enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)   // RQ1
        (access && pwrite && !pready && paddr == `KWU_ADDR_KEY_WAKE_ENABLE)
        |=> st_reg.en == $past(pwdata[7:4]))
        else $error("enable write lost");

    key_release_a: assert property (@(posedge pclk) disable iff (!presetn)    // RQ3
        (in_stop && st_reg.relm && key_req) |=> !in_stop && warmup_start)
        else $error("key low did not release stop");

    refuse_stop_a: assert property (@(posedge pclk) disable iff (!presetn)    // RQ4
        (st_reg.mode == KWU_RUN && stop_cmd && !pready && (prim_level || key_req))
        |=> warmup_start && !in_stop)
        else $error("stop entered with release active");

    level_mode_a: assert property (@(posedge pclk) disable iff (!presetn)     // RQ5
        (in_stop && st_reg.relm && prim_level) |=> !in_stop)
        else $error("level release missed");

    edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ6
        (in_stop && !st_reg.relm && !prim_edge) |=> in_stop)
        else $error("edge mode released without rising edge");

    prim_always_a: assert property (@(posedge pclk) disable iff (!presetn)    // RQ9
        (in_stop && prim_edge) |=> !in_stop ##1 st_reg.mode == KWU_RUN)
        else $error("primary pin release missed");

    single_req_a: assert property (@(posedge pclk) disable iff (!presetn)     // RQ12
        warmup_start |-> $past(release_req) || $past(prim_level) || $past(key_req))
        else $error("warm-up without release request");

    level_or_a: assert property (@(posedge pclk) disable iff (!presetn)       // RQ12
        st_reg.relm |-> release_req == (prim_level || key_req))
        else $error("level request is not the or of its sources");

    stay_stop_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ3
        (in_stop && !release_req) |=> in_stop)
        else $error("stop left without release request");

    stop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)     // RQ4
        (st_reg.mode == KWU_RUN && stop_cmd && !pready
         && !(prim_level || key_req || (st_reg.relm && release_req)))
        |=> in_stop && !warmup_start)
        else $error("stop not entered while sources idle");

    // ************************************************************
    // mode checks
    // ************************************************************
    // warm-up is a single cycle before the block is back in run
    warmup_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)   // RQ4
        warmup_start |=> !warmup_start)
        else $error("warm-up pulse longer than one cycle");

    warmup_run_a: assert property (@(posedge pclk) disable iff (!presetn)     // RQ4
        warmup_start |=> st_reg.mode == KWU_RUN)
        else $error("mode not back in run after warm-up");

    stop_flag_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ3
        in_stop == (st_reg.mode == KWU_STOP))
        else $error("stop flag disagrees with mode");

    mode_legal_a: assert property (@(posedge pclk) disable iff (!presetn)     // RQ4
        st_reg.mode != 2'b11)
        else $error("illegal mode code");

    relm_reset_a: assert property (@(posedge pclk)                            // RQ6
        $rose(presetn) |-> !st_reg.relm)
        else $error("release mode not edge after reset");

    // the stable copy may only follow once two sampler stages agree
    sync_agree_a: assert property (@(posedge pclk) disable iff (!presetn)     // RQ9
        $changed(st_reg.stable.stop_pin) |-> $past(st_reg.s2.stop_pin == st_reg.s3.stop_pin))
        else $error("primary pin accepted before sampler agreed");

    // ************************************************************
    // register bus checks
    // ************************************************************
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)       // RQ1
        (access && !pready) |=> pready)
        else $error("no answer after one wait state");

    apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ1
        pready |=> !pready)
        else $error("ready longer than one cycle");

    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ1
        pslverr |-> pready)
        else $error("error without ready");

    data_idle_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ1
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer cycle");

    err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)   // RQ1
        (access && !pready && paddr != `KWU_ADDR_KEY_WAKE_ENABLE
         && paddr != `KWU_ADDR_CTRL && paddr != `KWU_ADDR_STATUS)
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused");

    en_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)   // RQ1
        (access && !pwrite && !pready && paddr == `KWU_ADDR_KEY_WAKE_ENABLE)
        |=> prdata == 32'h0000_0000)
        else $error("write-only enables read back");

    enable_hold_a: assert property (@(posedge pclk) disable iff (!presetn)    // RQ1
        !(access && pwrite && !pready && paddr == `KWU_ADDR_KEY_WAKE_ENABLE)
        |=> $stable(st_reg.en))
        else $error("enables changed without a write");

    ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)      // RQ5
        (access && !pwrite && !pready && paddr == `KWU_ADDR_CTRL)
        |=> prdata == {31'h0000_0000, $past(st_reg.relm)})
        else $error("release mode read back wrong");

    // status shows the stop flag in bit zero
    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)    // RQ3
        (access && !pwrite && !pready && paddr == `KWU_ADDR_STATUS)
        |=> prdata[0] == $past(st_reg.in_stop))
        else $error("status stop flag wrong");

    // a refused stop must never also raise the stop flag
    refuse_flag_a: assert property (@(posedge pclk) disable iff (!presetn)    // RQ4
        warmup_start |-> !in_stop)
        else $error("stop flag high during warm-up");

endmodule : kwu_key_wakeup

/* File: test/kwu_keys.sv */
module kwu_keys
    import kwu_pkg::*;
(
    input  wire logic       pclk,      // system clock
    input  wire logic       edge_mode, // stop is left by primary edge only
    input  wire logic       stop_lvl,  // wanted primary pin level
    input  wire logic [3:0] key_lvl,   // wanted key levels, five down to two
    output kwu_pins_t       pins       // levels seen by the block
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge pclk) begin
        pins.stop_pin <= stop_lvl;
        pins.key_pins <= edge_mode ? 4'hf : key_lvl;
    end
endmodule : kwu_keys

/* File: test/test_key_wakeup_stop_release.sv */
`include "kwu_params.svh"
module test_key_wakeup_stop_release;
    timeunit 1ns;
    timeprecision 1ps;
    import kwu_pkg::*;
    typedef struct packed {
        logic relm; logic [3:0] en; logic s0; logic [3:0] k0;
        logic ent;  logic s1;       logic [3:0] k1; logic rel;
    } kwu_row_t;
    kwu_row_t rows [8] = '{
        '{1'b1, 4'hf, 1'b0, 4'hf, 1'b1, 1'b0, 4'he, 1'b1},
        '{1'b1, 4'h1, 1'b0, 4'hd, 1'b1, 1'b0, 4'hd, 1'b0},
        '{1'b1, 4'h1, 1'b0, 4'he, 1'b0, 1'b0, 4'hf, 1'b0},
        '{1'b1, 4'h0, 1'b1, 4'hf, 1'b0, 1'b0, 4'hf, 1'b0},
        '{1'b0, 4'h0, 1'b1, 4'hf, 1'b0, 1'b0, 4'hf, 1'b0},
        '{1'b0, 4'h0, 1'b0, 4'hf, 1'b1, 1'b1, 4'hf, 1'b1},
        '{1'b1, 4'h0, 1'b0, 4'hf, 1'b1, 1'b1, 4'hf, 1'b1},
        '{1'b1, 4'h8, 1'b0, 4'hf, 1'b1, 1'b0, 4'h7, 1'b1}};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, in_stop, warmup_start, er, relm_s = 1'b0, stop_lvl = 1'b0;
    logic [3:0]  key_lvl = 4'hf;
    kwu_pins_t   pins;
    int          fail_count = 0, samples_checked = 0, wu_cnt = 0, w0 = 0;
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (warmup_start === 1'b1) wu_cnt <= wu_cnt + 1;
    kwu_keys i_keys (.pclk(pclk), .edge_mode(~relm_s), .stop_lvl(stop_lvl),
                     .key_lvl(key_lvl), .pins(pins));
    kwu_key_wakeup i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_pin(pins.stop_pin), .key_wake_input_two(pins.key_pins[0]),
        .key_wake_input_three(pins.key_pins[1]), .key_wake_input_four(pins.key_pins[2]),
        .key_wake_input_five(pins.key_pins[3]), .in_stop(in_stop), .warmup_start(warmup_start));
    // ****************************************
    // bus, pin and check tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pins_go(input logic s, input logic [3:0] k);
        stop_lvl <= s;
        key_lvl <= k;
        repeat (8) @(posedge pclk);
    endtask : pins_go
    task automatic stop_try(input logic relm);
        apb(1'b1, `KWU_ADDR_CTRL, {31'h0, relm});
        w0 = wu_cnt;
        apb(1'b1, `KWU_ADDR_CTRL, {30'h0, 1'b1, relm});
        repeat (3) @(posedge pclk);
    endtask : stop_try
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (6) @(posedge pclk);
        chk({31'h0, in_stop}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, `KWU_ADDR_KEY_WAKE_ENABLE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 14'h0000, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        $display("test reset_and_map done");
        foreach (rows[i]) begin
            relm_s <= rows[i].relm;
            apb(1'b1, `KWU_ADDR_KEY_WAKE_ENABLE, {24'h0, rows[i].en, 4'h0});
            pins_go(rows[i].s0, rows[i].k0);
            stop_try(rows[i].relm);
            chk({31'h0, in_stop}, {31'h0, rows[i].ent});
            chk(wu_cnt - w0, {31'h0, !rows[i].ent});
            pins_go(rows[i].s1, rows[i].k1);
            chk({31'h0, in_stop}, {31'h0, rows[i].ent & !rows[i].rel});
            pins_go(1'b1, 4'hf);
            pins_go(1'b0, 4'hf);
            $display("test row %0d done", i);
        end
        relm_s <= 1'b1;
        apb(1'b1, `KWU_ADDR_KEY_WAKE_ENABLE, 32'hf0);
        stop_try(1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, in_stop}, 32'h0);
        presetn <= 1'b1;
        pins_go(1'b0, 4'h0);
        stop_try(1'b1);
        chk({31'h0, in_stop}, 32'h1);
        apb(1'b0, `KWU_ADDR_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `KWU_ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        pins_go(1'b1, 4'h0);
        chk({31'h0, in_stop}, 32'h0);
        $display("test mid_run_reset done");
        give_verdict();
    end
    initial begin
        #100us;
        fail_count++;
        give_verdict();
    end
endmodule : test_key_wakeup_stop_release
